// ==== hdl/cfg_word_map.svh ====
`ifndef CFG_WORD_MAP_SVH
`define CFG_WORD_MAP_SVH
// ==========================================
// Register map, byte addresses on the bus
`define REG_PERIOD_OFF 18'h0_0000
`define REG_WINDOW_OFF 18'h0_0004
`define REG_STATUS_OFF 18'h0_0008
`define REG_DIVEXP_OFF 18'h0_000C
// Printed word indices; byte address is four times the index
`define USER_ID0_IDX 16'h8000
`define USER_ID3_IDX 16'h8003
`define REV_WORD_IDX 16'h8005
`define PART_WORD_IDX 16'h8006
`define LOCK_WORD_IDX 16'h8007
// ==========================================
// Reset values and special codes
`define PERIOD_SW_CODE 5'h1F
`define PERIOD_SW_INIT 5'h0B
`define PERIOD_MAX_CODE 5'h12
`define PERIOD_MIN_CODE 5'h00
`define PERIOD_EXP_BASE 5'h05
`define WINDOW_SW_MIN 3'h6
`define WINDOW_OPEN_ALL 3'h7
`define ERASED_WORD 14'h3FFF
`define PROG_LAST_ADDR 12'hFFF
`define WRT_BOOT_TOP 12'h1FF
`define WRT_HALF_TOP 12'h7FF
// ==========================================
// Status register bit positions
`define ST_CP_LOCK 0
`define ST_SW_PERIOD 1
`define ST_SW_WINDOW 2
`define ST_ERASING 3
`define ST_WRT_LSB 4
`endif

// ==== hdl/cfg_word_pkg.sv ====
package cfg_word_pkg;
  // Fuse fields sampled after reset
  typedef struct packed {
    logic [2:0] window_cfg;
    logic [4:0] period_cfg;
    logic code_protect_n;
    logic [1:0] self_write_protect_field;
  } cfg_fuse_t;
  // One memory access request
  typedef struct packed {
    logic req;
    logic we;
    logic [15:0] addr;
    logic [13:0] wdata;
  } mem_req_t;
  // One memory access answer
  typedef struct packed {
    logic ack;
    logic refused;
    logic [13:0] rdata;
  } mem_rsp_t;
  typedef enum logic [1:0] {ST_LOAD, ST_RUN, ST_ERASE} ctl_state_t;
endpackage

// ==== hdl/config_word_protect_and_id.sv ====
`timescale 1ns/1ps
`include "cfg_word_map.svh"
module config_word_protect_and_id #(
  parameter logic [13:0] PART_CODE = 14'h0A5A, // Arbitrary value
  parameter logic [13:0] REV_CODE = 14'h0001 // Arbitrary value
) (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire cfg_word_pkg::cfg_fuse_t fuse_i,
  input wire cfg_word_pkg::mem_req_t cpu_req_i,
  output cfg_word_pkg::mem_rsp_t cpu_rsp_o,
  input wire cfg_word_pkg::mem_req_t ext_req_i,
  output cfg_word_pkg::mem_rsp_t ext_rsp_o,
  input wire logic bulk_erase_i,
  output logic [4:0] watchdog_period_runtime_o,
  output logic [2:0] window_delay_eighths_o,
  output logic wdt_ready_o,
  input wire logic [17:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [17:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  import cfg_word_pkg::*;

  // ==========================================
  // Word space decode shared by all ports
  function automatic logic is_prog(input logic [15:0] a);
    is_prog = (a[15:12] == 4'h0);
  endfunction
  function automatic logic is_uid(input logic [15:0] a);
    is_uid = (a >= `USER_ID0_IDX) && (a <= `USER_ID3_IDX);
  endfunction
  // Read one word from any space
  function automatic logic [13:0] word_rd(input logic [15:0] a,
      input logic [13:0] pm, input logic [13:0] ui);
    if (is_prog(a)) begin
      word_rd = pm;
    end else if (is_uid(a)) begin
      word_rd = ui;
    end else if (a == `PART_WORD_IDX) begin
      word_rd = PART_CODE;
    end else if (a == `REV_WORD_IDX) begin
      word_rd = REV_CODE;
    end else begin
      word_rd = 14'h0000;
    end
  endfunction

  // ==========================================
  // Storage
  logic [13:0] prog_mem [0:4095]; // Program words
  logic [13:0] uid_mem [0:3]; // User ID words
  ctl_state_t state_r; // Control state
  logic [11:0] erase_ptr_r; // Erase walk pointer
  cfg_fuse_t fuse_r; // Fuses caught after reset
  logic cp_lock_r; // Code protection active
  logic [4:0] period_r; // Runtime period
  logic [2:0] window_r; // Runtime window code
  logic sw_period_r; // Software owns period
  logic sw_window_r; // Software owns window
  mem_rsp_t cpu_rsp_r, ext_rsp_r; // Port answers

  // ==========================================
  // Decoders
  logic [4:0] period_init;
  logic period_sw;
  logic cpu_wr_blocked;
  wdt_period_decode u_period (
    .period_cfg_i(fuse_i.period_cfg),
    .period_init_o(period_init),
    .sw_ctl_o(period_sw)
  );
  self_write_guard u_guard (
    .self_write_protect_field_i(fuse_r.self_write_protect_field),
    .addr_i(cpu_req_i.addr[11:0]),
    .blocked_o(cpu_wr_blocked)
  );

  // ==========================================
  // Memory port decode
  wire running = (state_r == ST_RUN);
  wire ext_go = running && ext_req_i.req && !cp_lock_r;
  wire ext_wr = ext_go && ext_req_i.we;
  wire ext_pm_wr = ext_wr && is_prog(ext_req_i.addr);
  wire ext_ui_wr = ext_wr && is_uid(ext_req_i.addr);
  wire ext_lock_wr = running && ext_req_i.req && ext_req_i.we &&
    (ext_req_i.addr == `LOCK_WORD_IDX) && !ext_req_i.wdata[0];
  wire cpu_wr = running && cpu_req_i.req && cpu_req_i.we;
  // Self-write ok outside protected block, yields to external write
  wire cpu_pm_ok = is_prog(cpu_req_i.addr) && !cpu_wr_blocked &&
    !ext_pm_wr;
  wire cpu_ui_ok = is_uid(cpu_req_i.addr) && !ext_ui_wr;
  wire cpu_pm_wr = cpu_wr && cpu_pm_ok;
  wire cpu_ui_wr = cpu_wr && cpu_ui_ok;
  wire [13:0] cpu_rd = word_rd(cpu_req_i.addr, prog_mem[cpu_req_i.addr[11:0]],
    uid_mem[cpu_req_i.addr[1:0]]);
  wire [13:0] ext_rd = word_rd(ext_req_i.addr, prog_mem[ext_req_i.addr[11:0]],
    uid_mem[ext_req_i.addr[1:0]]);

  // ==========================================
  // AXI write side
  logic aw_held_r, w_held_r; // Address and data captured
  logic [17:0] awaddr_r; // Captured write address
  logic [31:0] wdata_r; // Captured write data
  logic [3:0] wstrb_r; // Captured strobes
  logic bvalid_r; // Write answer pending
  logic [1:0] bresp_r; // Write answer code
  wire [15:0] aw_idx = awaddr_r[17:2];
  // Own registers match on the full byte address
  wire aw_per = (awaddr_r == `REG_PERIOD_OFF);
  wire aw_win = (awaddr_r == `REG_WINDOW_OFF);
  wire aw_ro = (awaddr_r == `REG_STATUS_OFF) || (awaddr_r == `REG_DIVEXP_OFF);
  wire aw_uid = (awaddr_r[17:16] == 2'b10) && is_uid(aw_idx);
  // Identification words accept the write and keep their value
  wire aw_idw = (awaddr_r[17:16] == 2'b10) &&
    ((aw_idx == `PART_WORD_IDX) || (aw_idx == `REV_WORD_IDX));
  wire aw_hit = aw_per || aw_win || aw_ro || aw_uid || aw_idw;
  wire wr_fire = aw_held_r && w_held_r && !bvalid_r;
  wire low_lane = wstrb_r[0];
  wire axi_per_wr = wr_fire && aw_per && low_lane && sw_period_r;
  wire axi_win_wr = wr_fire && aw_win && low_lane && sw_window_r;
  wire axi_uid_wr = wr_fire && aw_uid && running;
  wire [4:0] new_period = (wdata_r[4:0] > `PERIOD_MAX_CODE) ?
    `PERIOD_MIN_CODE : wdata_r[4:0];
  assign s_axi_awready = !aw_held_r;
  assign s_axi_wready = !w_held_r;
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;

  // Capture address and data in either order
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      aw_held_r <= 1'b0;
      w_held_r <= 1'b0;
      bvalid_r <= 1'b0;
      bresp_r <= 2'b00;
      awaddr_r <= 18'h0_0000;
      wdata_r <= 32'h0000_0000;
      wstrb_r <= 4'h0;
    end else begin
      if (s_axi_awvalid && !aw_held_r) begin
        aw_held_r <= 1'b1;
        awaddr_r <= s_axi_awaddr;
      end
      if (s_axi_wvalid && !w_held_r) begin
        w_held_r <= 1'b1;
        wdata_r <= s_axi_wdata;
        wstrb_r <= s_axi_wstrb;
      end
      if (wr_fire) begin
        bvalid_r <= 1'b1;
        bresp_r <= aw_hit ? 2'b00 : 2'b10;
      end
      // Release both holds once the answer is taken
      if (bvalid_r && s_axi_bready) begin
        bvalid_r <= 1'b0;
        aw_held_r <= 1'b0;
        w_held_r <= 1'b0;
      end
    end
  end

  // ==========================================
  // AXI read side
  logic rvalid_r; // Read answer pending
  logic [31:0] rdata_r; // Read data
  logic [1:0] rresp_r; // Read answer code
  wire [15:0] ar_idx = s_axi_araddr[17:2];
  wire ar_far = (s_axi_araddr[17:16] == 2'b10);
  wire [31:0] status_word = {24'h00_0000, 2'b00, fuse_r.self_write_protect_field,
    state_r == ST_ERASE, sw_window_r, sw_period_r, cp_lock_r};
  wire [5:0] div_exp = {1'b0, period_r} + {1'b0, `PERIOD_EXP_BASE};
  logic [31:0] ar_data;
  logic ar_hit;
  // Register read select
  always_comb begin
    ar_data = 32'h0000_0000;
    ar_hit = 1'b1;
    if (s_axi_araddr == `REG_PERIOD_OFF) begin
      ar_data = {27'h000_0000, period_r};
    end else if (s_axi_araddr == `REG_WINDOW_OFF) begin
      ar_data = {29'h0000_0000, window_r};
    end else if (s_axi_araddr == `REG_STATUS_OFF) begin
      ar_data = status_word;
    end else if (s_axi_araddr == `REG_DIVEXP_OFF) begin
      ar_data = {26'h000_0000, div_exp};
    end else if (ar_far && (is_uid(ar_idx) || ar_idx == `PART_WORD_IDX ||
        ar_idx == `REV_WORD_IDX)) begin
      ar_data = {18'h0_0000, word_rd(ar_idx, 14'h0000, uid_mem[ar_idx[1:0]])};
    end else begin
      ar_hit = 1'b0;
    end
  end
  assign s_axi_arready = !rvalid_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rdata = rdata_r;
  assign s_axi_rresp = rresp_r;

  // One read at a time, answer the cycle after the address
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      rvalid_r <= 1'b0;
      rdata_r <= 32'h0000_0000;
      rresp_r <= 2'b00;
    end else if (s_axi_arvalid && !rvalid_r) begin
      rvalid_r <= 1'b1;
      rdata_r <= ar_data;
      rresp_r <= ar_hit ? 2'b00 : 2'b10;
    end else if (rvalid_r && s_axi_rready) begin
      rvalid_r <= 1'b0;
    end
  end

  // ==========================================
  // Fuse load, watchdog settings, protection latch
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      state_r <= ST_LOAD;
      erase_ptr_r <= 12'h000;
      fuse_r <= '1;
      cp_lock_r <= 1'b0;
      period_r <= `PERIOD_MIN_CODE;
      window_r <= `WINDOW_OPEN_ALL;
      sw_period_r <= 1'b0;
      sw_window_r <= 1'b0;
    end else begin
      unique case (state_r)
        // First cycle after release catches the fuses
        ST_LOAD: begin
          fuse_r <= fuse_i;
          period_r <= period_init;
          sw_period_r <= period_sw;
          sw_window_r <= (fuse_i.window_cfg >= `WINDOW_SW_MIN);
          // Fuse codes never reach the 12.5% delay
          window_r <= (fuse_i.window_cfg >= `WINDOW_SW_MIN) ?
            `WINDOW_OPEN_ALL : fuse_i.window_cfg;
          if (!fuse_i.code_protect_n) begin
            cp_lock_r <= 1'b1;
          end
          state_r <= ST_RUN;
        end
        // Normal operation
        ST_RUN: begin
          if (axi_per_wr) begin
            period_r <= new_period;
          end
          if (axi_win_wr) begin
            window_r <= wdata_r[2:0];
          end
          if (ext_lock_wr) begin
            cp_lock_r <= 1'b1;
          end
          if (bulk_erase_i) begin
            erase_ptr_r <= 12'h000;
            state_r <= ST_ERASE;
          end
        end
        // Walk all program words, then lift protection
        ST_ERASE: begin
          erase_ptr_r <= erase_ptr_r + 12'h001;
          if (erase_ptr_r == `PROG_LAST_ADDR) begin
            cp_lock_r <= 1'b0;
            state_r <= ST_RUN;
          end
        end
      endcase
    end
  end

  // ==========================================
  // Memory writes: erase, then external, then bus (user ID only), then processor
  always_ff @(posedge clk_sys_i) begin
    if (state_r == ST_ERASE) begin
      prog_mem[erase_ptr_r] <= `ERASED_WORD;
      uid_mem[erase_ptr_r[1:0]] <= `ERASED_WORD;
    end else begin
      if (ext_pm_wr) begin
        prog_mem[ext_req_i.addr[11:0]] <= ext_req_i.wdata;
      end else if (cpu_pm_wr) begin
        prog_mem[cpu_req_i.addr[11:0]] <= cpu_req_i.wdata;
      end
      if (ext_ui_wr) begin
        uid_mem[ext_req_i.addr[1:0]] <= ext_req_i.wdata;
      end else if (axi_uid_wr) begin
        uid_mem[aw_idx[1:0]] <= wdata_r[13:0];
      end else if (cpu_ui_wr) begin
        uid_mem[cpu_req_i.addr[1:0]] <= cpu_req_i.wdata;
      end
    end
  end

  // ==========================================
  // Port answers, one cycle after the request
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      cpu_rsp_r <= '0;
      ext_rsp_r <= '0;
    end else begin
      cpu_rsp_r.ack <= cpu_req_i.req;
      cpu_rsp_r.refused <= cpu_req_i.req && (!running ||
        (cpu_req_i.we && !cpu_pm_ok && !cpu_ui_ok));
      cpu_rsp_r.rdata <= (running && !cpu_req_i.we) ? cpu_rd : 14'h0000;
      ext_rsp_r.ack <= ext_req_i.req;
      ext_rsp_r.refused <= ext_req_i.req && !ext_go && !ext_lock_wr;
      // Blocked external reads return zero
      ext_rsp_r.rdata <= (ext_go && !ext_req_i.we) ? ext_rd : 14'h0000;
    end
  end
  assign cpu_rsp_o = cpu_rsp_r;
  assign ext_rsp_o = ext_rsp_r;

  // ==========================================
  // Watchdog settings out
  assign watchdog_period_runtime_o = period_r;
  assign window_delay_eighths_o = 3'h7 - window_r;
  assign wdt_ready_o = (state_r != ST_LOAD);
endmodule // config_word_protect_and_id

// ==== hdl/self_write_guard.sv ====
`timescale 1ns/1ps
`include "cfg_word_map.svh"
module self_write_guard (
  input wire logic [1:0] self_write_protect_field_i,
  input wire logic [11:0] addr_i,
  output logic blocked_o
);
  // ==========================================
  // Protected block top per field code
  logic [11:0] top;
  logic any;
  always_comb begin
    top = `PROG_LAST_ADDR;
    any = 1'b1;
    unique case (self_write_protect_field_i)
      2'b11: any = 1'b0;
      2'b10: top = `WRT_BOOT_TOP;
      2'b01: top = `WRT_HALF_TOP;
      2'b00: top = `PROG_LAST_ADDR;
    endcase
  end
  // Protected block always starts at zero
  assign blocked_o = any && (addr_i <= top);
endmodule // self_write_guard

// ==== hdl/wdt_period_decode.sv ====
`timescale 1ns/1ps
`include "cfg_word_map.svh"
module wdt_period_decode (
  input wire logic [4:0] period_cfg_i,
  output logic [4:0] period_init_o,
  output logic sw_ctl_o
);
  // ==========================================
  // Fuse code to initial runtime period
  wire is_sw = (period_cfg_i == `PERIOD_SW_CODE);
  wire in_range = (period_cfg_i <= `PERIOD_MAX_CODE);
  assign sw_ctl_o = is_sw;
  // Reserved codes fall back to the shortest divider
  assign period_init_o = is_sw ? `PERIOD_SW_INIT :
    (in_range ? period_cfg_i : `PERIOD_MIN_CODE);
endmodule // wdt_period_decode

// ==== tb/cfg_word_chk.sv ====
`timescale 1ns/1ps
// ==========================================
// Port checker for the configuration block
module cfg_word_chk (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire cfg_word_pkg::cfg_fuse_t fuse_i,
  input wire cfg_word_pkg::mem_req_t cpu_req_i,
  input wire cfg_word_pkg::mem_rsp_t cpu_rsp_o,
  input wire cfg_word_pkg::mem_rsp_t ext_rsp_o,
  input wire logic [4:0] watchdog_period_runtime_o,
  input wire logic [2:0] window_delay_eighths_o,
  input wire logic wdt_ready_o
);
  import cfg_word_pkg::*;
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);
  logic [1:0] swp_w; // Self-write field
  logic [11:0] top_w; // Last guarded address
  logic guard_w; // Processor write into guarded block
  logic [4:0] per_w; // Period expected after load
  assign swp_w = fuse_i.self_write_protect_field;
  assign top_w = (swp_w == 2'b10) ? 12'h1FF : 12'h7FF;
  assign guard_w = cpu_req_i.req && cpu_req_i.we && (cpu_req_i.addr[15:12] == 4'h0)
    && ((swp_w == 2'b00) || ((swp_w != 2'b11) && (cpu_req_i.addr[11:0] <= top_w)));
  assign per_w = (fuse_i.period_cfg == 5'h1F) ? 5'h0B
    : ((fuse_i.period_cfg > 5'h12) ? 5'h00 : fuse_i.period_cfg);
  // Load finished after a reset
  sequence s_load;
    $rose(wdt_ready_o);
  endsequence
  // Processor write aimed at an identification word
  sequence s_id_write;
    cpu_req_i.req && cpu_req_i.we && (cpu_req_i.addr inside {16'h8005, 16'h8006});
  endsequence
  property p_ack_next;
    cpu_req_i.req |=> cpu_rsp_o.ack;
  endproperty
  a_ack_next: assert property (p_ack_next) else $error("access not acknowledged");
  property p_ext_zero;
    ext_rsp_o.ack && ext_rsp_o.refused |-> (ext_rsp_o.rdata == 14'h0000);
  endproperty
  a_ext_zero: assert property (p_ext_zero) else $error("blocked read not zero");
  property p_period_load;
    s_load |-> (watchdog_period_runtime_o == per_w);
  endproperty
  a_period_load: assert property (p_period_load) else $error("bad period");
  property p_period_held;
    wdt_ready_o && $past(wdt_ready_o) && (fuse_i.period_cfg != 5'h1F)
      |-> $stable(watchdog_period_runtime_o);
  endproperty
  a_period_held: assert property (p_period_held) else $error("period moved");
  property p_no_eighth;
    wdt_ready_o && (fuse_i.window_cfg < 3'h6) |-> (window_delay_eighths_o != 3'h1);
  endproperty
  a_no_eighth: assert property (p_no_eighth) else $error("eighth delay reached");
  property p_window_load;
    s_load |-> (window_delay_eighths_o
      == ((fuse_i.window_cfg < 3'h6) ? (3'h7 - fuse_i.window_cfg) : 3'h0));
  endproperty
  a_window_load: assert property (p_window_load) else $error("bad window");
  property p_id_refused;
    s_id_write |=> cpu_rsp_o.ack && cpu_rsp_o.refused;
  endproperty
  a_id_refused: assert property (p_id_refused) else $error("id write taken");
  property p_guard;
    guard_w |=> cpu_rsp_o.refused;
  endproperty
  a_guard: assert property (p_guard) else $error("guarded write taken");
endmodule // cfg_word_chk

// ==== tb/config_word_protect_and_id_bench.sv ====
`timescale 1ns/1ps
module config_word_protect_and_id_bench;
  import cfg_word_pkg::*;
  localparam logic [13:0] PART_V = 14'h1C3D; // Arbitrary value
  localparam logic [13:0] REV_V = 14'h0002; // Arbitrary value
  localparam logic [4:0] CODES [6] = '{5'h00, 5'h12, 5'h13, 5'h1E, 5'h1F, 5'h0B};
  localparam logic [11:0] ADDRS [6] = '{12'h000, 12'h1FF, 12'h200, 12'h7FF, 12'h800, 12'hFFF};
  logic clk_sys_i, rst_i, bulk_erase_i, wdt_ready_o, rf, ok;
  cfg_fuse_t fuse_i;
  mem_req_t cpu_req_i, ext_req_i;
  mem_rsp_t cpu_rsp_o, ext_rsp_o;
  logic [4:0] watchdog_period_runtime_o, p;
  logic [2:0] window_delay_eighths_o, w;
  logic [17:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rv, rs;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, rr;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [13:0] q, d;
  int n_errors, tests_run;
  config_word_protect_and_id #(.PART_CODE(PART_V), .REV_CODE(REV_V)) dut (.clk_sys_i, .rst_i,
    .fuse_i, .cpu_req_i, .cpu_rsp_o, .ext_req_i, .ext_rsp_o, .bulk_erase_i,
    .watchdog_period_runtime_o, .window_delay_eighths_o, .wdt_ready_o, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
  ext_tool_model tool (.clk_sys_i, .ext_req_o(ext_req_i), .ext_rsp_i(ext_rsp_o),
    .bulk_erase_o(bulk_erase_i));
  // ==========================================
  // Clock, checks and expectations
  initial begin
    clk_sys_i = 1'b0;
    forever #4 clk_sys_i = ~clk_sys_i;
  end
  function automatic logic [31:0] xs();
    rs ^= rs << 13;
    rs ^= rs >> 17;
    rs ^= rs << 5;
    return rs;
  endfunction
  function automatic logic [4:0] exp_per(input logic [4:0] c);
    return (c == 5'h1F) ? 5'h0B : ((c > 5'h12) ? 5'h00 : c);
  endfunction
  function automatic logic guarded(input logic [1:0] f, input logic [11:0] a);
    return (f == 2'b00) || ((f == 2'b10) && (a <= 12'h1FF)) || ((f == 2'b01) && (a <= 12'h7FF));
  endfunction
  task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    tests_run++;
    if (s !== e) begin
      n_errors++;
      $display("unexpected %s expected %h seen %h", nm, e, s);
    end
  endtask
  task end_of_test();
    $display("checks %0d mismatches %0d", tests_run, n_errors);
    if ((n_errors == 0) && (tests_run > 0)) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // ==========================================
  // Bus and port tasks
  task rst_with(input logic [2:0] fw, input logic [4:0] fp, input logic fc, input logic [1:0] fs);
    @(posedge clk_sys_i);
    rst_i <= 1'b1;
    fuse_i <= {fw, fp, fc, fs};
    repeat (8) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    repeat (3) @(posedge clk_sys_i);
  endtask
  task axi_wr(input logic [17:0] a, input logic [31:0] dd, output logic [1:0] r);
    int n;
    n = 0;
    @(posedge clk_sys_i);
    s_axi_awaddr <= a;
    s_axi_wdata <= dd;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (n < 40) begin
      @(posedge clk_sys_i);
      n++;
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid && s_axi_bready) begin
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
        n = 99;
      end
    end
    chk("write answer", 32'(n), 32'h0000_0063);
  endtask
  task axi_rd(input logic [17:0] a, output logic [31:0] dd, output logic [1:0] r);
    int n;
    n = 0;
    @(posedge clk_sys_i);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    while (n < 40) begin
      @(posedge clk_sys_i);
      n++;
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid && s_axi_rready) begin
        dd = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
        n = 99;
      end
    end
    chk("read answer", 32'(n), 32'h0000_0063);
  endtask
  task cpu(input logic we, input logic [15:0] a, input logic [13:0] dd);
    @(posedge clk_sys_i);
    cpu_req_i <= {1'b1, we, a, dd};
    @(posedge clk_sys_i);
    cpu_req_i <= '0;
    #1;
    chk("cpu ack", 32'(cpu_rsp_o.ack), 32'h0000_0001);
    q = cpu_rsp_o.rdata;
    rf = cpu_rsp_o.refused;
  endtask
  task ext(input logic we, input logic [15:0] a, input logic [13:0] dd);
    tool.access(we, a, dd, q, rf, ok);
    chk("tool ack", 32'(ok), 32'h0000_0001);
  endtask
  // Hang guard
  initial begin
    repeat (40000) @(posedge clk_sys_i);
    n_errors++;
    end_of_test();
  end
  // ==========================================
  // Main sequence
  initial begin
    rst_i = 1'b1;
    fuse_i = '1;
    cpu_req_i = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    s_axi_wstrb = 4'hF;
    n_errors = 0;
    tests_run = 0;
    rs = 32'h0000_9CF8; // Seed 40184
    for (int i = 0; i < 9; i++) begin
      rv = xs();
      p = (i < 6) ? CODES[i] : rv[4:0];
      rst_with(3'h7, p, 1'b1, 2'b11);
      chk("period", 32'(watchdog_period_runtime_o), 32'(exp_per(p)));
      axi_rd(18'h0_000C, rv, rr);
      chk("exponent", rv, 32'(exp_per(p)) + 32'h0000_0005);
    end
    for (int i = 0; i < 2; i++) begin
      p = i ? 5'h05 : 5'h1F;
      rst_with(3'h7, p, 1'b1, 2'b11);
      // Low lane off: period write must be dropped
      if (!i) begin
        s_axi_wstrb <= 4'hE;
        axi_wr(18'h0_0000, 32'h0000_0003, rr);
        s_axi_wstrb <= 4'hF;
        chk("strobe", 32'(watchdog_period_runtime_o), 32'h0000_000B);
      end
      axi_wr(18'h0_0000, 32'h0000_000E, rr);
      chk("sw period", 32'(watchdog_period_runtime_o), i ? 32'h5 : 32'hE);
      w = i ? 3'h3 : 3'h6;
      rst_with(w, 5'h00, 1'b1, 2'b11);
      axi_wr(18'h0_0004, 32'h0000_0006, rr);
      chk("window", 32'(window_delay_eighths_o), i ? 32'h4 : 32'h1);
    end
    $display("test watchdog decode done");
    for (int f = 0; f < 4; f++) begin
      rst_with(3'h7, 5'h00, 1'b1, 2'(f));
      for (int j = 0; j < 6; j++) begin
        rv = xs();
        cpu(1'b1, {4'h0, ADDRS[j]}, rv[13:0]);
        chk("guard", 32'(rf), 32'(guarded(2'(f), ADDRS[j])));
        cpu(1'b0, {4'h0, ADDRS[j]}, 14'h0000);
        if (!guarded(2'(f), ADDRS[j])) chk("self write", 32'(q), 32'(rv[13:0]));
      end
    end
    $display("test self write done");
    rst_with(3'h7, 5'h00, 1'b1, 2'b11);
    rv = xs();
    d = rv[13:0];
    ext(1'b1, 16'h0100, d);
    ext(1'b0, 16'h0100, 14'h0000);
    chk("open read", 32'(q), 32'(d));
    ext(1'b1, 16'h8007, 14'h0000);
    ext(1'b1, 16'h0100, ~d);
    ext(1'b0, 16'h0100, 14'h0000);
    chk("locked read", 32'({rf, q}), 32'h0000_4000);
    cpu(1'b0, 16'h0100, 14'h0000);
    chk("cpu read", 32'({rf, q}), 32'(d));
    tool.erase();
    rv = 32'h0000_0008;
    for (int n = 0; (n < 3000) && rv[3]; n++) axi_rd(18'h0_0008, rv, rr);
    ext(1'b0, 16'h0100, 14'h0000);
    chk("erased read", 32'({rf, q}), 32'h0000_3FFF);
    rst_with(3'h7, 5'h00, 1'b0, 2'b11);
    ext(1'b0, 16'h0100, 14'h0000);
    chk("fuse locked", 32'({rf, q}), 32'h0000_4000);
    cpu(1'b0, 16'h0100, 14'h0000);
    chk("cpu free", 32'(rf), 32'h0000_0000);
    $display("test code protect done");
    rst_with(3'h7, 5'h00, 1'b1, 2'b11);
    for (int i = 0; i < 4; i++) begin
      rv = xs();
      cpu(1'b1, 16'h8000 + 16'(i), rv[13:0]);
      ext(1'b0, 16'h8000 + 16'(i), 14'h0000);
      chk("user id", 32'(q), 32'(rv[13:0]));
    end
    axi_wr(18'h2_0004, 32'h0000_1234, rr);
    axi_rd(18'h2_0004, rv, rr);
    chk("user id bus", rv, 32'h0000_1234);
    cpu(1'b1, 16'h8006, ~PART_V);
    ext(1'b1, 16'h8005, ~REV_V);
    axi_wr(18'h2_0018, 32'h0000_0000, rr);
    chk("id write resp", 32'(rr), 32'h0000_0000);
    axi_wr(18'h0_0100, 32'h0000_0000, rr);
    chk("unmapped write", 32'(rr), 32'h0000_0002);
    ext(1'b0, 16'h8006, 14'h0000);
    chk("part word", 32'(q), 32'(PART_V));
    axi_rd(18'h2_0014, rv, rr);
    chk("revision word", rv, 32'(REV_V));
    axi_rd(18'h0_0100, rv, rr);
    chk("unmapped", 32'(rr), 32'h0000_0002);
    $display("test identification done");
    end_of_test();
  end
endmodule // config_word_protect_and_id_bench

bind config_word_protect_and_id cfg_word_chk u_chk (.clk_sys_i, .rst_i, .fuse_i, .cpu_req_i,
  .cpu_rsp_o, .ext_rsp_o, .watchdog_period_runtime_o, .window_delay_eighths_o, .wdt_ready_o);

// ==== tb/ext_tool_model.sv ====
`timescale 1ns/1ps
// ==========================================
// Programmer stand-in on the external port
module ext_tool_model (
  input wire logic clk_sys_i,
  output cfg_word_pkg::mem_req_t ext_req_o,
  input wire cfg_word_pkg::mem_rsp_t ext_rsp_i,
  output logic bulk_erase_o
);
  import cfg_word_pkg::*;
  initial begin
    ext_req_o = '0;
    bulk_erase_o = 1'b0;
  end
  // One word; released lines carry the inverse of the last value
  task automatic access(input logic we, input logic [15:0] a, input logic [13:0] d,
      output logic [13:0] q, output logic rf, output logic ok);
    @(posedge clk_sys_i);
    ext_req_o <= {1'b1, we, a, d};
    @(posedge clk_sys_i);
    ext_req_o <= {1'b0, ~we, ~a, ~d};
    #1;
    ok = ext_rsp_i.ack;
    q = ext_rsp_i.rdata;
    rf = ext_rsp_i.refused;
  endtask
  // One-cycle bulk erase pulse
  task automatic erase();
    @(posedge clk_sys_i);
    bulk_erase_o <= 1'b1;
    @(posedge clk_sys_i);
    bulk_erase_o <= 1'b0;
  endtask
endmodule // ext_tool_model
